// *** logic/ppbc_top.sv ***
// Port power and battery charge control for a two-port hub.
// Assumes register accesses come from the serial management decoder on the
// core clock; strap, config select and over-current inputs are raw pins.
//
// Overview of operation
// - Charging ports power on after reset and configuration
// - Power-on ignores enumeration and bus voltage detect
// - Over-current removes that port's power
// - After shutoff, only host request or reset restores
// - Report latched over-current once hub is enumerated
// - Enable register bit 1 port 1, bit 2 port 2
// - Each enabled port has its power output asserted
// - Register selects per port; strap only port 1
// - Straps honoured only when configuration enables them
// - Strap high gives 1, strap low gives 0
// - LED drive polarity follows sampled LED strap
// - Select 0 uses straps; 1 uses register settings
// - During reset, charging ports keep power on
`timescale 1ns/1ns
`default_nettype none

module ppbc_top (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic config_select_in,
  input wire logic config_load_done_in,
  input wire logic charge_enable_strap_port1_in,
  input wire logic led_pin_in,
  input wire logic led_activity_in,
  input wire logic [ppbc_pkg::NUM_PORTS-1:0] over_current_n_in,
  input wire logic hub_enumerated_in,
  input wire logic [ppbc_pkg::NUM_PORTS-1:0] host_port_power_req_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  output logic [ppbc_pkg::NUM_PORTS-1:0] port_power_out,
  output logic [ppbc_pkg::NUM_PORTS-1:0] over_current_status_out,
  output logic led_pin_out,
  output logic led_pin_oe_n_out,
  output logic config_done_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Synchronised pins
  logic cfg_sel_sync; // Configuration select level
  logic strap_bc1_sync; // Port 1 charge strap level
  logic led_strap_sync; // LED pin level while released
  logic [ppbc_pkg::NUM_PORTS-1:0] oc_n_sync; // Over-current, active low

  // Configuration sequence
  ppbc_pkg::ppbc_cfg_state_t cfg_state; // Current step
  logic [3:0] strap_count; // Cycles spent in strap window

  // Captured straps
  logic strap_bc1; // Port 1 charge enable from strap
  logic led_strap; // LED polarity strap
  logic straps_on; // Straps were enabled at capture

  // Register state
  logic [7:0] bc_reg; // Battery charge enable register

  // Effective charge enables and their reset-surviving copy
  logic [ppbc_pkg::NUM_PORTS-1:0] charge_en;
  logic [ppbc_pkg::NUM_PORTS-1:0] charge_retain;
  logic [ppbc_pkg::NUM_PORTS-1:0] oc_active;
  logic [ppbc_pkg::NUM_PORTS-1:0] oc_flag;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Config select and straps idle low, matching the internal pull-downs
  ppbc_sync2 #(
    .WIDTH(3),
    .RESET_VAL(3'h0)
  ) u_sync_straps (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in({config_select_in, charge_enable_strap_port1_in, led_pin_in}),
    .sync_out({cfg_sel_sync, strap_bc1_sync, led_strap_sync})
  );

  // Over-current pins idle high, so reset does not fake a fault
  ppbc_sync2 #(
    .WIDTH(ppbc_pkg::NUM_PORTS),
    .RESET_VAL({ppbc_pkg::NUM_PORTS{1'b1}})
  ) u_sync_oc (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(over_current_n_in),
    .sync_out(oc_n_sync)
  );

  // Active-high over-current seen by the port logic
  assign oc_active = ~oc_n_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration sequence

  // Strap window, then either straps or a wait for the register load
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_state <= ppbc_pkg::CFG_STRAP_WAIT;
      strap_count <= 4'h0;
    end else begin
      case (cfg_state)
        ppbc_pkg::CFG_STRAP_WAIT: begin
          // Count out setup time and synchroniser latency
          if (strap_count == ppbc_pkg::STRAP_WINDOW_LAST) begin
            if (cfg_sel_sync) begin
              cfg_state <= ppbc_pkg::CFG_LOAD_WAIT;
            end else begin
              cfg_state <= ppbc_pkg::CFG_RUN;
            end
          end else begin
            strap_count <= strap_count + 4'h1;
          end
        end
        ppbc_pkg::CFG_LOAD_WAIT: begin
          // Waits as long as the register load takes
          if (config_load_done_in) begin
            cfg_state <= ppbc_pkg::CFG_RUN;
          end
        end
        ppbc_pkg::CFG_RUN: begin
          // Stays here until the next hardware reset
          cfg_state <= ppbc_pkg::CFG_RUN;
        end
        default: begin
          cfg_state <= ppbc_pkg::CFG_STRAP_WAIT;
        end
      endcase
    end
  end

  // Configuration complete flag, the gate for port power outside reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      config_done_out <= 1'b0;
    end else begin
      config_done_out <= (cfg_state == ppbc_pkg::CFG_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture

  // Sampled once at the end of the window; pin level maps straight to value
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_bc1 <= 1'b0;
      led_strap <= 1'b0;
      straps_on <= 1'b0;
    end else if (cfg_state == ppbc_pkg::CFG_STRAP_WAIT &&
                 strap_count == ppbc_pkg::STRAP_WINDOW_LAST) begin
      straps_on <= !cfg_sel_sync;
      strap_bc1 <= strap_bc1_sync && !cfg_sel_sync;
      led_strap <= led_strap_sync && !cfg_sel_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  // Writes only land when registers come from the management interface;
  // in the default configuration the register keeps its reset value
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bc_reg <= ppbc_pkg::BC_REG_RESET;
    end else if (reg_write_in && cfg_sel_sync && reg_addr_in == ppbc_pkg::BC_REG_OFFSET) begin
      bc_reg <= reg_wdata_in;
    end
  end

  // Read data, registered; unmapped offsets read as zero
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        ppbc_pkg::BC_REG_OFFSET: begin
          reg_rdata_out <= bc_reg;
        end
        ppbc_pkg::STATUS_REG_OFFSET: begin
          reg_rdata_out <= 8'h00;
          reg_rdata_out[ppbc_pkg::STAT_POWER_LSB +: ppbc_pkg::NUM_PORTS] <= port_power_out;
          reg_rdata_out[ppbc_pkg::STAT_OC_LSB +: ppbc_pkg::NUM_PORTS] <= oc_flag;
          reg_rdata_out[ppbc_pkg::STAT_CFG_DONE_BIT] <= config_done_out;
          reg_rdata_out[ppbc_pkg::STAT_STRAP_BC1_BIT] <= strap_bc1;
          reg_rdata_out[ppbc_pkg::STAT_LED_STRAP_BIT] <= led_strap;
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Effective charge enables

  // Register bits select any port; the strap reaches only port 1
  always_comb begin
    charge_en[0] = bc_reg[ppbc_pkg::BC_PORT1_BIT] || strap_bc1;
    charge_en[1] = bc_reg[ppbc_pkg::BC_PORT2_BIT];
  end

  // Copy without reset so a held hardware reset keeps charging ports powered.
  // Limitation: from power-up until the first run the copy is unknown.
  always_ff @(posedge clock_in) begin
    if (rst_n_in && config_done_out) begin
      charge_retain <= charge_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port power control

  generate
    for (genvar p = 0; p < ppbc_pkg::NUM_PORTS; p++) begin : g_port
      ppbc_port_ctl u_port (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .cfg_done_in(config_done_out),
        .charge_enable_in(charge_en[p]),
        .charge_retain_in(charge_retain[p]),
        .over_current_in(oc_active[p]),
        .hub_enumerated_in(hub_enumerated_in),
        .power_req_in(host_port_power_req_in[p]),
        .power_out(port_power_out[p]),
        .oc_flag_out(oc_flag[p]),
        .oc_status_out(over_current_status_out[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // LED drive

  // Pin stays released until configuration so its strap can be read;
  // a strap sampled high means the LED hangs from the supply, active low
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_pin_out <= 1'b0;
      led_pin_oe_n_out <= 1'b1;
    end else begin
      led_pin_out <= led_activity_in ^ led_strap;
      led_pin_oe_n_out <= !config_done_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_charge_power_on: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    config_done_out && charge_en[0] && !oc_flag[0] && !oc_active[0]
      |=> port_power_out[0]
  ) else $error("charging port 1 not powered after configuration");

  a_no_power_early: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    !config_done_out |=> port_power_out == '0 || $past(!rst_n_in)
  ) else $error("port powered before configuration");

  a_port2_enable: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    config_done_out && bc_reg[ppbc_pkg::BC_PORT2_BIT] && !oc_flag[1] && !oc_active[1]
      |=> port_power_out[1]
  ) else $error("enabled port 2 not powered");

  a_reg_write: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_write_in && cfg_sel_sync && reg_addr_in == ppbc_pkg::BC_REG_OFFSET
      |=> bc_reg == $past(reg_wdata_in)
  ) else $error("charge enable register write lost");

  a_strap_ignored: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    !straps_on |-> !strap_bc1 && !led_strap
  ) else $error("strap honoured while straps disabled");

  a_strap_window: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    $rose(config_done_out) |-> $past(straps_on) || $past(config_load_done_in, 2)
  ) else $error("configuration finished without straps or load");

  a_led_polarity: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    config_done_out ##1 1'b1 |-> led_pin_out == ($past(led_activity_in) ^ $past(led_strap))
      && !led_pin_oe_n_out
  ) else $error("LED drive polarity wrong");

  // Case equality: before the first run both the copy and the output are unknown
  a_reset_keeps_power: assert property (
    @(posedge clock_in)
    !rst_n_in && $past(!rst_n_in) |=> port_power_out === $past(charge_retain)
  ) else $error("charging port power dropped in reset");

endmodule

`default_nettype wire

// *** logic/ppbc_pkg.sv ***
// Constants shared by the port power and battery charge control block.
// Assumes a 100 MHz core clock; all counts are derived from it here.
package ppbc_pkg;

  // Core clock period, used to turn times into cycle counts
  localparam int CLK_PERIOD_PS = 10000;

  // Number of downstream ports handled by this block
  localparam int NUM_PORTS = 2;

  // Register offsets on the configuration register port
  localparam logic [7:0] BC_REG_OFFSET = 8'hd0;
  localparam logic [7:0] STATUS_REG_OFFSET = 8'hd1;

  // Field positions in the battery charge enable register
  localparam int BC_PORT1_BIT = 1;
  localparam int BC_PORT2_BIT = 2;

  // Reset value of the battery charge enable register
  localparam logic [7:0] BC_REG_RESET = 8'h00;

  // Field positions in the status register
  localparam int STAT_POWER_LSB = 0;
  localparam int STAT_OC_LSB = 2;
  localparam int STAT_CFG_DONE_BIT = 4;
  localparam int STAT_STRAP_BC1_BIT = 5;
  localparam int STAT_LED_STRAP_BIT = 6;

  // Least strap setup time after reset release, in picoseconds
  localparam int STRAP_SETUP_PS = 16700;
  // Strap settle cycles after release, rounded up, at least one
  localparam int STRAP_WAIT_CYCLES = (STRAP_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Last strap window count: settle time plus two sync stages; the window spans one cycle more
  localparam logic [3:0] STRAP_WINDOW_LAST = 4'(STRAP_WAIT_CYCLES + 2);

  // Configuration sequence states
  typedef enum logic [1:0] {
    CFG_STRAP_WAIT,
    CFG_LOAD_WAIT,
    CFG_RUN
  } ppbc_cfg_state_t;

endpackage

// *** logic/ppbc_sync2.sv ***
// Two-stage level synchroniser for pins entering the core clock domain.
// Assumes the input is a slow level; a pulse that spans no rising clock edge is lost.
`timescale 1ns/1ns
`default_nettype none

module ppbc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  ////////////////////////////////////////////////////////////////////////////////
  // Both stages reset to the idle level of the pin
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// *** logic/ppbc_port_ctl.sv ***
// Power control for one downstream port: over-current shutoff and restore.
// Assumes over-current and config inputs are already in the core clock domain.
`timescale 1ns/1ns
`default_nettype none

module ppbc_port_ctl (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cfg_done_in,
  input wire logic charge_enable_in,
  input wire logic charge_retain_in,
  input wire logic over_current_in,
  input wire logic hub_enumerated_in,
  input wire logic power_req_in,
  output logic power_out,
  output logic oc_flag_out,
  output logic oc_status_out
);

  // Host has asked for power on this port since reset
  logic host_on;
  // Power level for the next cycle outside reset
  logic next_power;

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky shutoff flag; a new detection beats a same-cycle restore request
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_flag_out <= 1'b0;
    end else if (over_current_in) begin
      oc_flag_out <= 1'b1;
    end else if (power_req_in) begin
      oc_flag_out <= 1'b0;
    end
  end

  // Host request latch, cleared only by hardware reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_on <= 1'b0;
    end else if (power_req_in) begin
      host_on <= 1'b1;
    end
  end

  // Charging ports need neither enumeration nor bus voltage, only config done
  always_comb begin
    next_power = cfg_done_in && (charge_enable_in || host_on)
      && !oc_flag_out && !over_current_in;
  end

  // No async reset here: while reset is held the port keeps its charging power.
  // Reset is sampled as a level, so release may lag one cycle; harmless here.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      power_out <= charge_retain_in;
    end else begin
      power_out <= next_power;
    end
  end

  // Over-current is reported only once a host has enumerated the hub
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_status_out <= 1'b0;
    end else begin
      oc_status_out <= hub_enumerated_in && oc_flag_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the shutoff and restore behaviour

  a_oc_cuts_power: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    over_current_in |=> !power_out && oc_flag_out
  ) else $error("power not removed after over-current");

  a_flag_holds_off: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    oc_flag_out && !power_req_in |=> oc_flag_out && !power_out
  ) else $error("shutoff flag lost without host request");

  a_req_restores: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    oc_flag_out && power_req_in && !over_current_in && cfg_done_in
      ##1 !over_current_in && cfg_done_in |=> power_out
  ) else $error("host request did not restore power");

  a_status_report: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    hub_enumerated_in && oc_flag_out |=> oc_status_out
  ) else $error("over-current status not reported");

endmodule

`default_nettype wire

// *** tb/ppbc_far_model.sv ***
// Far side of the port power block: two power switches and the upstream host.
// Assumes the bench sets load faults and host actions through the tasks here.
`timescale 1ns/1ns
`default_nettype none

module ppbc_far_model (
  input wire logic clock_in,
  input wire logic [1:0] port_power_in,
  output logic [1:0] over_current_n_out,
  output logic [1:0] host_port_power_req_out,
  output logic hub_enumerated_out
);
  // Shorted load per port, set by the bench
  logic [1:0] short_load = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // A switch flags only while it feeds a shorted load; otherwise its
  // open-drain flag is released and the pull-up makes the pin high
  assign over_current_n_out = ~(short_load & port_power_in);

  // Host idle and hub not enumerated at start
  initial begin
    host_port_power_req_out = 2'h0;
    hub_enumerated_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Put a short on a port or take it away
  task automatic set_short(input int port, input logic v);
    @(posedge clock_in);
    short_load[port] <= v;
  endtask

  // Host enumerates the hub or drops it
  task automatic set_enumerated(input logic v);
    @(posedge clock_in);
    hub_enumerated_out <= v;
  endtask

  // One-cycle port power request from the host
  task automatic request_power(input int port);
    @(posedge clock_in);
    host_port_power_req_out[port] <= 1'b1;
    @(posedge clock_in);
    host_port_power_req_out[port] <= 1'b0;
  endtask
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the port power and battery charge control block.
// Assumes the far model stands in for power switches and host.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic clock_in;
  logic rst_n_in;
  logic config_select_in;
  logic config_load_done_in;
  logic charge_enable_strap_port1_in;
  logic led_strap; // External strap level on the LED pin
  logic led_activity_in;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_write_in;
  logic reg_read_in;
  logic [7:0] reg_rdata_out;
  logic [1:0] port_power_out;
  logic [1:0] over_current_status_out;
  logic led_pin_out;
  logic led_pin_oe_n_out;
  logic config_done_out;
  logic [1:0] over_current_n;
  logic [1:0] host_req;
  logic hub_enum;
  logic [1:0] power_in_reset; // Port power seen late in the last reset
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  // Pin level: the hub's drive when enabled, else the strap resistor
  wire logic led_pin_in = led_pin_oe_n_out ? led_strap : led_pin_out;

  ppbc_top dut (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .config_select_in(config_select_in),
    .config_load_done_in(config_load_done_in),
    .charge_enable_strap_port1_in(charge_enable_strap_port1_in),
    .led_pin_in(led_pin_in),
    .led_activity_in(led_activity_in),
    .over_current_n_in(over_current_n),
    .hub_enumerated_in(hub_enum),
    .host_port_power_req_in(host_req),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out),
    .port_power_out(port_power_out),
    .over_current_status_out(over_current_status_out),
    .led_pin_out(led_pin_out),
    .led_pin_oe_n_out(led_pin_oe_n_out),
    .config_done_out(config_done_out)
  );

  ppbc_far_model far (
    .clock_in(clock_in),
    .port_power_in(port_power_out),
    .over_current_n_out(over_current_n),
    .host_port_power_req_out(host_req),
    .hub_enumerated_out(hub_enum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // Hang guard: the tests need well under a thousand cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("BAD run length expected finish seen hang");
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Byte comparison, case equality so an unknown seen never matches a known expected bit
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Port power comparison
  task automatic check_power(input logic [1:0] exp);
    check8("port power", {6'h0, exp}, {6'h0, port_power_out});
  endtask

  // Wait for edges, then let their updates land
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // Reset with pins set; straps stay put well past release
  task automatic do_reset(input logic sel, input logic bc1, input logic led);
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    config_select_in <= sel;
    config_load_done_in <= 1'b0;
    charge_enable_strap_port1_in <= bc1;
    led_strap <= led;
    tick(3);
    power_in_reset = port_power_out;
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    config_load_done_in <= sel;
  endtask

  // Bounded wait for configuration, then one edge for power to follow
  task automatic wait_done;
    int n = 0;
    while (config_done_out !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check8("config done", 8'h01, {7'h0, config_done_out});
    tick(1);
  endtask

  // Register write; returns once the port outputs have followed
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
    tick(2);
  endtask

  // Register read; data is taken once it has been registered
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    tick(1);
    d = reg_rdata_out;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Strap mode, never enumerated: port 1 follows its strap, writes ignored
  task automatic t_strap(input logic bc1, input logic led);
    logic [7:0] d;
    do_reset(1'b0, bc1, led);
    wait_done();
    check_power({1'b0, bc1});
    reg_write(8'hd0, 8'h06);
    check_power({1'b0, bc1});
    reg_read(8'hd1, d);
    check8("strap status", {1'b0, led, bc1, 5'h0}, d & 8'h60);
    for (int act = 0; act < 2; act++) begin
      @(posedge clock_in);
      led_activity_in <= act[0];
      tick(3);
      check8("led drive", {6'h0, 1'b0, act[0] ^ led},
             {6'h0, led_pin_oe_n_out, led_pin_out});
    end
    $display("test strap mode done");
  endtask

  // Register mode: strap ignored, enable bits per port, read back
  task automatic t_reg_mode;
    logic [7:0] d;
    logic [7:0] wd [4] = '{8'h06, 8'h02, 8'hf9, 8'h04};
    logic [1:0] ep [4] = '{2'b11, 2'b01, 2'b00, 2'b10};
    do_reset(1'b1, 1'b1, 1'b0);
    wait_done();
    check_power(2'b00);
    for (int i = 0; i < 4; i++) begin
      reg_write(8'hd0, wd[i]);
      check_power(ep[i]);
      reg_read(8'hd0, d);
      check8("enable readback", wd[i], d);
    end
    reg_write(8'h33, 8'hff);
    check_power(2'b10);
    reg_read(8'h55, d);
    check8("unmapped read", 8'h00, d);
    $display("test register mode done");
  endtask

  // Power held through reset for charging ports only, off after release
  task automatic t_reset_retain;
    do_reset(1'b1, 1'b0, 1'b0);
    check8("power in reset", 8'h02, {6'h0, power_in_reset});
    tick(1);
    check_power(2'b00);
    wait_done();
    check_power(2'b00);
    reg_write(8'hd0, 8'h02);
    do_reset(1'b1, 1'b0, 1'b0);
    check8("power in reset", 8'h01, {6'h0, power_in_reset});
    wait_done();
    reg_write(8'hd0, 8'h06);
    check_power(2'b11);
    $display("test reset retention done");
  endtask

  // Over-current shutoff, sticky flag, report, restore by host and reset
  task automatic t_overcurrent;
    logic [7:0] d;
    far.set_short(1, 1'b1);
    tick(6);
    check_power(2'b01);
    far.set_short(1, 1'b0);
    reg_write(8'hd0, 8'h06);
    check_power(2'b01);
    reg_read(8'hd1, d);
    check8("shutoff status", 8'h19, d & 8'h1f);
    check8("oc report", 8'h00, {6'h0, over_current_status_out});
    far.set_enumerated(1'b1);
    tick(3);
    check8("oc report", 8'h02, {6'h0, over_current_status_out});
    far.request_power(1);
    tick(3);
    check_power(2'b11);
    check8("oc report", 8'h00, {6'h0, over_current_status_out});
    far.set_enumerated(1'b0);
    far.set_short(0, 1'b1);
    tick(6);
    check_power(2'b10);
    far.set_short(0, 1'b0);
    do_reset(1'b1, 1'b0, 1'b0);
    wait_done();
    reg_write(8'hd0, 8'h06);
    check_power(2'b11);
    $display("test over-current done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset is low from time zero
  initial begin
    rst_n_in = 1'b0;
    config_select_in = 1'b0;
    config_load_done_in = 1'b0;
    charge_enable_strap_port1_in = 1'b0;
    led_strap = 1'b0;
    led_activity_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    t_strap(1'b1, 1'b1);
    t_strap(1'b0, 1'b0);
    t_reg_mode();
    t_reset_retain();
    t_overcurrent();
    report_and_stop();
  end
endmodule

`default_nettype wire
